// >>> core/cpc_pkg.sv
// Constants and types shared by the copper control block
package cpc_pkg;
	localparam int CPC_ADDR_W = 5;
	localparam int CPC_DATA_W = 16;
	localparam logic [4:0] CPC_REG_CTRL1 = 5'h10;
	localparam int CPC_BIT_LP = 15;
	localparam int CPC_RETRY_HI = 14;
	localparam int CPC_RETRY_LO = 12;
	localparam int CPC_BIT_DS_EN = 11;
	localparam int CPC_BIT_FLG = 10;
	localparam int CPC_ED_HI = 9;
	localparam int CPC_ED_LO = 7;
	localparam int CPC_MDIX_HI = 6;
	localparam int CPC_MDIX_LO = 5;
	localparam int CPC_BIT_WAKE = 4;
	localparam int CPC_BIT_TXDIS = 3;
	localparam int CPC_BIT_PD = 2;
	localparam int CPC_BIT_POL = 1;
	localparam int CPC_BIT_JAB = 0;
	localparam logic [2:0] CPC_RETRY_RST = 3'h3;
	localparam logic [2:0] CPC_ED_RST = 3'h0;
	localparam logic [1:0] CPC_MDIX_RST = 2'h3;
	localparam logic [1:0] CPC_MDIX_MDI = 2'h0;
	localparam logic [1:0] CPC_MDIX_MDIX = 2'h1;
	localparam logic [1:0] CPC_MDIX_AUTO = 2'h3;
	localparam logic [1:0] CPC_SPEED_10 = 2'h0;
	localparam logic [1:0] CPC_SPEED_1000 = 2'h2;
	typedef enum logic {CPC_PS_ACTIVE, CPC_PS_DOWN} cpc_pstate_e;
endpackage

// >>> core/cpc_downshift.sv
// Gigabit attempt counter deciding speed downshift
`timescale 1ns/100ps
`default_nettype none
module cpc_downshift (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic enable,
	input wire logic [2:0] retry,
	input wire logic gig_fail,
	output logic downshift_q
);
	typedef struct packed {
		logic [2:0] cnt;
		logic hit;
	} cpc_ds_s;
	cpc_ds_s q;
	cpc_ds_s d;

	always_comb begin
		d = q;
		if (clear) begin
			d = '0;
		end else if (gig_fail && enable && !q.hit) begin
			if (q.cnt == retry) begin
				d.hit = 1'b1;
			end else begin
				d.cnt = q.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign downshift_q = q.hit;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	ds_count_a: assert property (
		(enable && !clear && !q.hit && gig_fail && q.cnt == retry) |=> downshift_q
	) else $error("Downshift missed after last retry");
	ds_hold_a: assert property (
		(!enable && !q.hit) |=> !downshift_q
	) else $error("Downshift while disabled");
	ds_seen_c: cover property (clear ##1 (gig_fail [*4]) ##1 downshift_q);
endmodule
`default_nettype wire

// >>> core/cpc_ctrl.sv
// Copper control register with deferred fields and power-down sequencing
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Link-pulse bit set stops link pulses; clear sends them; resets to zero.
// - Gigabit attempts equal retry field plus one, then drop speed; resets to three.
// - Downshift enable and retry count take effect only at software reset.
// - Forced link good reports link up, except in gigabit operation.
// - Energy-detect field: 0xx off, 1x0 auto wake, 1x1 software wake, 11x pulses.
// - Crossover field: 00 MDI, 01 MDI-X, 10 reserved, 11 automatic.
// - Hardware reset or negotiation restart reloads crossover field from strap.
// - Crossover field change takes effect only at software reset.
// - Wake bit writable in software-wake mode; one wakes; read-only otherwise.
// - Wake bit clears itself once the PHY leaves energy-detect sleep.
// - Transmitter disable bit turns transmitter off; survives software reset.
// - Power-down is OR of this bit and basic control power-down.
// - Leaving power-down self-issues software reset and negotiation restart.
// - Polarity reversal disable forces normal polarity in 10BASE-T.
// - Jabber disable turns jabber off; jabber acts only in 10 half duplex.
// - Manual crossover status follows the applied crossover field.
module cpc_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [cpc_pkg::CPC_ADDR_W-1:0] reg_addr,
	input wire logic [cpc_pkg::CPC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cpc_pkg::CPC_DATA_W-1:0] reg_rdata_q,
	input wire logic sw_reset_req,
	input wire logic an_restart_req,
	input wire logic basic_pd,
	input wire logic auto_xover_strap,
	input wire logic [1:0] link_speed,
	input wire logic full_duplex,
	input wire logic ed_sleep,
	input wire logic line_energy,
	input wire logic auto_xover_result,
	input wire logic gig_fail,
	output logic link_pulse_off_q,
	output logic [2:0] retry_q,
	output logic downshift_en_q,
	output logic downshift_q,
	output logic link_forced_up_q,
	output logic ed_enable_q,
	output logic ed_tx_pulses_q,
	output logic ed_wake_q,
	output logic force_mdix_q,
	output logic auto_xover_q,
	output logic xover_status_q,
	output logic tx_off_q,
	output logic power_down_q,
	output logic polarity_fixed_q,
	output logic jabber_en_q,
	output logic sw_reset_out_q,
	output logic an_restart_out_q
);
	typedef struct packed {
		logic lp_dis;
		logic [2:0] sh_retry;
		logic sh_ds_en;
		logic force_lg;
		logic [2:0] sh_ed;
		logic [1:0] sh_mdix;
		logic wake;
		logic tx_dis;
		logic pd;
		logic pol_dis;
		logic jab_dis;
		logic [2:0] ac_retry;
		logic ac_ds_en;
		logic [2:0] ac_ed;
		logic [1:0] ac_mdix;
		logic strap_done;
		logic sleep_prev;
		cpc_pkg::cpc_pstate_e pstate;
		logic [15:0] rdata;
		logic forced_up;
		logic ed_wake;
		logic xo_status;
		logic pd_out;
		logic pol_fix;
		logic jab_en;
		logic rst_out;
		logic mdix_forced;
		logic xover_auto;
		logic ed_pulses;
	} cpc_ctrl_s;

	localparam cpc_ctrl_s RST_Q = '{
		lp_dis: 1'b0, sh_retry: cpc_pkg::CPC_RETRY_RST, sh_ds_en: 1'b0, force_lg: 1'b0,
		sh_ed: cpc_pkg::CPC_ED_RST, sh_mdix: cpc_pkg::CPC_MDIX_RST, wake: 1'b0, tx_dis: 1'b0,
		pd: 1'b0, pol_dis: 1'b0, jab_dis: 1'b0, ac_retry: cpc_pkg::CPC_RETRY_RST, ac_ds_en: 1'b0,
		ac_ed: cpc_pkg::CPC_ED_RST, ac_mdix: cpc_pkg::CPC_MDIX_RST, strap_done: 1'b0,
		sleep_prev: 1'b0, pstate: cpc_pkg::CPC_PS_ACTIVE, rdata: 16'h0000, forced_up: 1'b0,
		ed_wake: 1'b0, xo_status: 1'b1, pd_out: 1'b0, pol_fix: 1'b0, jab_en: 1'b0, rst_out: 1'b0,
		mdix_forced: 1'b0, xover_auto: 1'b1, ed_pulses: 1'b0
	};

	cpc_ctrl_s q;
	cpc_ctrl_s d;
	logic hit;
	logic pd_any;
	logic self_rst;
	logic any_rst;

	// Bits 9 and 7 both set select the software wake codes
	function automatic logic ed_sw_wake(input logic [2:0] mode);
		ed_sw_wake = mode[2] & mode[0];
	endfunction

	function automatic logic is_10m(input logic [1:0] spd);
		is_10m = (spd == cpc_pkg::CPC_SPEED_10);
	endfunction

	assign hit = (reg_addr == cpc_pkg::CPC_REG_CTRL1);
	assign pd_any = q.pd | basic_pd;
	assign self_rst = (q.pstate == cpc_pkg::CPC_PS_DOWN) && !pd_any;
	assign any_rst = sw_reset_req | self_rst;

	always_comb begin
		d = q;
		d.rdata = 16'h0000;
		d.sleep_prev = ed_sleep;
		if (reg_rd && hit) begin
			d.rdata = {q.lp_dis, q.sh_retry, q.sh_ds_en, q.force_lg, q.sh_ed, q.sh_mdix,
				q.wake, q.tx_dis, q.pd, q.pol_dis, q.jab_dis};
		end
		if (q.sleep_prev && !ed_sleep) begin
			d.wake = 1'b0;
		end
		if (reg_wr && hit) begin
			d.lp_dis = reg_wdata[cpc_pkg::CPC_BIT_LP];
			d.sh_retry = reg_wdata[cpc_pkg::CPC_RETRY_HI:cpc_pkg::CPC_RETRY_LO];
			d.sh_ds_en = reg_wdata[cpc_pkg::CPC_BIT_DS_EN];
			d.sh_ed = reg_wdata[cpc_pkg::CPC_ED_HI:cpc_pkg::CPC_ED_LO];
			d.sh_mdix = reg_wdata[cpc_pkg::CPC_MDIX_HI:cpc_pkg::CPC_MDIX_LO];
			d.force_lg = reg_wdata[cpc_pkg::CPC_BIT_FLG];
			d.tx_dis = reg_wdata[cpc_pkg::CPC_BIT_TXDIS];
			d.pd = reg_wdata[cpc_pkg::CPC_BIT_PD];
			d.pol_dis = reg_wdata[cpc_pkg::CPC_BIT_POL];
			d.jab_dis = reg_wdata[cpc_pkg::CPC_BIT_JAB];
			if (ed_sw_wake(q.ac_ed)) begin
				d.wake = reg_wdata[cpc_pkg::CPC_BIT_WAKE];
			end
		end
		case (q.pstate)
			cpc_pkg::CPC_PS_ACTIVE: begin
				if (pd_any) begin
					d.pstate = cpc_pkg::CPC_PS_DOWN;
				end
			end
			cpc_pkg::CPC_PS_DOWN: begin
				if (!pd_any) begin
					d.pstate = cpc_pkg::CPC_PS_ACTIVE;
				end
			end
			default: begin
				d.pstate = cpc_pkg::CPC_PS_ACTIVE;
			end
		endcase
		if (any_rst) begin
			d.ac_retry = d.sh_retry;
			d.ac_ds_en = d.sh_ds_en;
			d.ac_ed = d.sh_ed;
			d.ac_mdix = d.sh_mdix;
			d.lp_dis = 1'b0;
			d.wake = 1'b0;
		end
		// strap reload, also once after reset release
		if (an_restart_req || self_rst || !q.strap_done) begin
			d.sh_mdix = {2{auto_xover_strap}};
			d.ac_mdix = {2{auto_xover_strap}};
			d.strap_done = 1'b1;
		end
		d.rst_out = self_rst;
		d.pd_out = pd_any;
		d.forced_up = d.force_lg && (link_speed != cpc_pkg::CPC_SPEED_1000);
		// wake by energy or by bit
		d.ed_wake = d.ac_ed[2] && ed_sleep && (ed_sw_wake(d.ac_ed) ? d.wake : line_energy);
		if (d.ac_mdix == cpc_pkg::CPC_MDIX_AUTO) begin
			d.xo_status = auto_xover_result;
		end else begin
			d.xo_status = (d.ac_mdix == cpc_pkg::CPC_MDIX_MDIX);
		end
		d.pol_fix = d.pol_dis && is_10m(link_speed);
		// jabber only in 10 half duplex
		d.jab_en = !d.jab_dis && is_10m(link_speed) && !full_duplex;
		// Decoded here so every output leaves a flip-flop
		d.mdix_forced = (d.ac_mdix == cpc_pkg::CPC_MDIX_MDIX);
		d.xover_auto = (d.ac_mdix == cpc_pkg::CPC_MDIX_AUTO);
		d.ed_pulses = d.ac_ed[2] & d.ac_ed[1];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST_Q;
		end else begin
			q <= d;
		end
	end

	// Counter cleared by every reset so a new retry value starts fresh
	cpc_downshift u_downshift (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clear(any_rst),
		.enable(q.ac_ds_en),
		.retry(q.ac_retry),
		.gig_fail(gig_fail),
		.downshift_q(downshift_q)
	);

	assign reg_rdata_q = q.rdata;
	assign link_pulse_off_q = q.lp_dis;
	assign retry_q = q.ac_retry;
	assign downshift_en_q = q.ac_ds_en;
	assign link_forced_up_q = q.forced_up;
	assign ed_enable_q = q.ac_ed[2];
	assign ed_tx_pulses_q = q.ed_pulses;
	assign ed_wake_q = q.ed_wake;
	assign force_mdix_q = q.mdix_forced;
	assign auto_xover_q = q.xover_auto;
	assign xover_status_q = q.xo_status;
	assign tx_off_q = q.tx_dis;
	assign power_down_q = q.pd_out;
	assign polarity_fixed_q = q.pol_fix;
	assign jabber_en_q = q.jab_en;
	assign sw_reset_out_q = q.rst_out;
	assign an_restart_out_q = q.rst_out;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	link_pulse_a: assert property (
		(reg_wr && hit && !sw_reset_req && !self_rst) |=> (link_pulse_off_q == $past(reg_wdata[15]))
	) else $error("Link pulse bit not taken");
	retry_defer_a: assert property (
		(reg_wr && hit && !any_rst) |=> $stable(retry_q) && $stable(downshift_en_q)
	) else $error("Retry applied without reset");
	retry_apply_a: assert property (
		(reg_wr && hit && sw_reset_req) |=> (retry_q == $past(reg_wdata[14:12]))
	) else $error("Retry not applied at reset");
	forced_gig_a: assert property (
		(link_speed == cpc_pkg::CPC_SPEED_1000) |=> !link_forced_up_q
	) else $error("Forced link up at gigabit");
	ed_off_a: assert property (
		!ed_enable_q |-> (!ed_tx_pulses_q && !ed_wake_q)
	) else $error("Energy detect active while off");
	strap_reload_a: assert property (
		an_restart_req |=> (auto_xover_q == $past(auto_xover_strap)) && !force_mdix_q
	) else $error("Crossover not reloaded");
	mdix_defer_a: assert property (
		(reg_wr && hit && !any_rst && !an_restart_req && q.strap_done) |=> $stable(auto_xover_q)
	) else $error("Crossover applied without reset");
	wake_ro_a: assert property (
		(reg_wr && hit && !ed_sw_wake(q.ac_ed) && !q.wake) |=> !q.wake
	) else $error("Wake bit written in auto mode");
	wake_clear_a: assert property (
		(q.sleep_prev && !ed_sleep && !(reg_wr && hit)) |=> !q.wake
	) else $error("Wake bit not cleared");
	txd_keep_a: assert property (
		(sw_reset_req && !(reg_wr && hit)) |=> $stable(tx_off_q)
	) else $error("Transmit disable lost at reset");
	pd_or_a: assert property (
		basic_pd |=> power_down_q
	) else $error("Basic power-down ignored");
	pd_exit_a: assert property (
		$fell(power_down_q) |-> (sw_reset_out_q && an_restart_out_q) ##1 !sw_reset_out_q
	) else $error("No reset on power-down exit");
	pol_fix_a: assert property (
		(link_speed != cpc_pkg::CPC_SPEED_10) |=> !polarity_fixed_q
	) else $error("Polarity forced outside 10BASE-T");
	jab_mode_a: assert property (
		(full_duplex || link_speed != cpc_pkg::CPC_SPEED_10) |=> !jabber_en_q
	) else $error("Jabber active outside 10 half");
	xo_status_a: assert property (
		(!auto_xover_q ##1 !auto_xover_q) |-> (xover_status_q == force_mdix_q)
	) else $error("Manual crossover status wrong");
	rd_idle_a: assert property (
		!(reg_rd && hit) |=> (reg_rdata_q == 16'h0000)
	) else $error("Read data outside read cycle");
	wake_write_a: assert property (
		(reg_wr && hit && ed_sw_wake(q.ac_ed) && reg_wdata[cpc_pkg::CPC_BIT_WAKE] && !any_rst) |=> q.wake
	) else $error("Wake bit write lost");
	pd_bit_a: assert property (
		q.pd |=> power_down_q
	) else $error("Power-down bit ignored");
	lp_reset_a: assert property (
		any_rst |=> !link_pulse_off_q
	) else $error("Link pulse bit kept over reset");

	pd_cycle_c: cover property (power_down_q ##[1:20] sw_reset_out_q);
	sw_wake_c: cover property (ed_enable_q && ed_sleep ##1 ed_wake_q);
	mdix_apply_c: cover property ((reg_wr && hit) ##[1:5] sw_reset_req ##1 force_mdix_q);
endmodule
`default_nettype wire

// >>> tb/cpc_core_model.sv
// Behavioural model of the PHY core beside the control block
`timescale 1ns/100ps
`default_nettype none
module cpc_core_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sleep_cmd,
	input wire logic fail_cmd,
	input wire logic ed_wake_q,
	output logic ed_sleep,
	output logic line_energy,
	output logic gig_fail
);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ed_sleep <= 1'b0;
			gig_fail <= 1'b0;
		end else begin
			// core leaves sleep on wake request
			if (ed_wake_q) begin
				ed_sleep <= 1'b0;
			end else if (sleep_cmd) begin
				ed_sleep <= 1'b1;
			end
			// one failed gigabit attempt per command
			gig_fail <= fail_cmd;
		end
	end
	// Quiet line, so only the software wake path can end sleep
	assign line_energy = 1'b0;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Register and sequencing tests of the copper control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk, rst_n, reg_wr, reg_rd, sw_reset_req, an_restart_req, basic_pd, strap, fd, xres;
	logic sleep_cmd, fail_cmd, ed_sleep, line_energy, gig_fail;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata_q;
	logic [1:0] speed;
	logic [2:0] retry_q;
	logic link_pulse_off_q, downshift_en_q, downshift_q, link_forced_up_q, ed_enable_q, ed_tx_pulses_q;
	logic ed_wake_q, force_mdix_q, auto_xover_q, xover_status_q, tx_off_q, power_down_q;
	logic polarity_fixed_q, jabber_en_q, sw_reset_out_q, an_restart_out_q;
	int mismatches, samples_checked, n, i;

	cpc_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sw_reset_req(sw_reset_req),
		.an_restart_req(an_restart_req), .basic_pd(basic_pd), .auto_xover_strap(strap),
		.link_speed(speed), .full_duplex(fd), .ed_sleep(ed_sleep), .line_energy(line_energy),
		.auto_xover_result(xres), .gig_fail(gig_fail), .link_pulse_off_q(link_pulse_off_q),
		.retry_q(retry_q), .downshift_en_q(downshift_en_q), .downshift_q(downshift_q),
		.link_forced_up_q(link_forced_up_q), .ed_enable_q(ed_enable_q), .ed_tx_pulses_q(ed_tx_pulses_q),
		.ed_wake_q(ed_wake_q), .force_mdix_q(force_mdix_q), .auto_xover_q(auto_xover_q),
		.xover_status_q(xover_status_q), .tx_off_q(tx_off_q), .power_down_q(power_down_q),
		.polarity_fixed_q(polarity_fixed_q), .jabber_en_q(jabber_en_q),
		.sw_reset_out_q(sw_reset_out_q), .an_restart_out_q(an_restart_out_q));

	cpc_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .sleep_cmd(sleep_cmd), .fail_cmd(fail_cmd),
		.ed_wake_q(ed_wake_q), .ed_sleep(ed_sleep), .line_energy(line_energy), .gig_fail(gig_fail));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_q, exp);
	endtask

	task automatic swr();
		@(posedge sys_clk);
		sw_reset_req <= 1'b1;
		@(posedge sys_clk);
		sw_reset_req <= 1'b0;
		tick(2);
	endtask

	task automatic fail_once();
		@(posedge sys_clk);
		fail_cmd <= 1'b1;
		@(posedge sys_clk);
		fail_cmd <= 1'b0;
		tick(3);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		rst_n = 1'b0;
		{reg_wr, reg_rd, sw_reset_req, an_restart_req, basic_pd, fd, xres, sleep_cmd, fail_cmd} = '0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		strap = 1'b1;
		speed = 2'h0;
		mismatches = 0;
		samples_checked = 0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		begin : tests
			tick(2);
			rd(5'h10, 16'h3060);
			chk(16'({retry_q, auto_xover_q, jabber_en_q}), 16'h0F);
			wr(5'h10, 16'hB46B);
			tick(2);
			chk(16'({link_pulse_off_q, tx_off_q, polarity_fixed_q, jabber_en_q, link_forced_up_q}),
				16'h1D);
			@(posedge sys_clk);
			speed <= 2'h2;
			tick(3);
			chk(16'({link_forced_up_q, polarity_fixed_q}), 16'h0);
			@(posedge sys_clk);
			speed <= 2'h0;
			wr(5'h10, 16'h0AA8);
			tick(2);
			rd(5'h10, 16'h0AA8);
			chk(16'({retry_q, downshift_en_q, auto_xover_q}), 16'h0D);
			swr();
			chk(16'({retry_q, downshift_en_q, force_mdix_q, auto_xover_q, xover_status_q, ed_enable_q, tx_off_q}),
				16'h37);
			chk(16'(downshift_q), 16'h0);
			fail_once();
			chk(16'(downshift_q), 16'h1);
			@(posedge sys_clk);
			sleep_cmd <= 1'b1;
			@(posedge sys_clk);
			sleep_cmd <= 1'b0;
			tick(2);
			chk(16'({ed_sleep, ed_wake_q}), 16'h2);
			wr(5'h10, 16'h0AB8);
			n = 0;
			while (ed_wake_q !== 1'b1 && n < 20) begin
				tick(1);
				n++;
			end
			chk(16'(ed_wake_q), 16'h1);
			if (ed_wake_q !== 1'b1)
				disable tests;
			tick(4);
			chk(16'({ed_sleep, ed_wake_q}), 16'h0);
			rd(5'h10, 16'h0AA8);
			wr(5'h10, 16'h0AAC);
			tick(2);
			chk(16'(power_down_q), 16'h1);
			@(posedge sys_clk);
			basic_pd <= 1'b1;
			wr(5'h10, 16'h0AA8);
			tick(2);
			chk(16'(power_down_q), 16'h1);
			@(posedge sys_clk);
			basic_pd <= 1'b0;
			tick(1);
			chk(16'({power_down_q, sw_reset_out_q, an_restart_out_q}), 16'h3);
			tick(1);
			chk(16'({sw_reset_out_q, an_restart_out_q, downshift_q, auto_xover_q}), 16'h1);
			rd(5'h10, 16'h0AE8);
			@(posedge sys_clk);
			strap <= 1'b0;
			an_restart_req <= 1'b1;
			@(posedge sys_clk);
			an_restart_req <= 1'b0;
			tick(2);
			chk(16'(auto_xover_q), 16'h0);
			wr(5'h11, 16'hFFFF);
			rd(5'h11, 16'h0000);
			rd(5'h10, 16'h0A88);
			// Every sleep code and crossover code, applied at software reset
			for (i = 0; i < 8; i++) begin
				wr(5'h10, 16'(32'h0808 | (i << 7) | ((i & 3) << 5)));
				swr();
				chk(16'({ed_enable_q, ed_tx_pulses_q, force_mdix_q, auto_xover_q, xover_status_q}),
					16'({i[2], i[2] & i[1], (i & 3) == 1, (i & 3) == 3, (i & 3) == 1}));
			end
			// Two attempts before downshift; wake bit locked in auto wake mode
			wr(5'h10, 16'h1A00);
			swr();
			chk(16'({retry_q, downshift_en_q, ed_enable_q}), 16'h07);
			wr(5'h10, 16'h1A10);
			rd(5'h10, 16'h1A00);
			fail_once();
			chk(16'(downshift_q), 16'h0);
			fail_once();
			chk(16'(downshift_q), 16'h1);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
